// >>> otd_pkg.sv
package otd_pkg;

	localparam int OTD_SAMPLE_W = 16;
	localparam int OTD_CNT_W    = 10;

	// Bit positions in the orientation status byte
	localparam int OTD_POS_XL    = 0;
	localparam int OTD_POS_XH    = 1;
	localparam int OTD_POS_YL    = 2;
	localparam int OTD_POS_YH    = 3;
	localparam int OTD_POS_ZL    = 4;
	localparam int OTD_POS_ZH    = 5;
	localparam int OTD_STATUS_IA = 6;

	// Sine of 80/70/60/50 degrees in Q8
	localparam logic [7:0] OTD_ANGLE_K0 = 8'hfc;
	localparam logic [7:0] OTD_ANGLE_K1 = 8'hf1;
	localparam logic [7:0] OTD_ANGLE_K2 = 8'hde;
	localparam logic [7:0] OTD_ANGLE_K3 = 8'hc4;

	// Tap windows in sample periods
	localparam logic [9:0] OTD_SHOCK_DEF = 10'h004;
	localparam logic [9:0] OTD_SHOCK_LSB = 10'h008;
	localparam logic [9:0] OTD_QUIET_DEF = 10'h002;
	localparam logic [9:0] OTD_QUIET_LSB = 10'h004;
	localparam logic [9:0] OTD_DUR_DEF   = 10'h010;
	localparam logic [9:0] OTD_DUR_LSB   = 10'h020;

	// One tap threshold step is full scale over 32
	localparam int          OTD_TAP_THS_SHIFT = 10;
	localparam logic [15:0] OTD_ONE_G_DEF     = 16'h4000;

	typedef logic signed [15:0] otd_smp_t;

	typedef struct packed {
		otd_smp_t x;
		otd_smp_t y;
		otd_smp_t z;
	} otd_axes_t;

	typedef struct packed {
		logic       global_event_enable;
		logic       latch_request_mode;
		logic       orient_lowpass_select;
		logic       four_way_orient_enable;
		logic [1:0] orient_angle_threshold;
		logic       orient_route_pin_one;
		logic       orient_route_pin_two;
		logic [2:0] tap_axis_enable;
		logic [4:0] tap_threshold_x;
		logic [4:0] tap_threshold_y;
		logic [4:0] tap_threshold_z;
		logic       single_double_tap_select;
		logic       single_tap_route_one;
		logic       single_tap_route_two;
		logic       double_tap_route_one;
		logic       double_tap_route_two;
		logic [1:0] shock_code;
		logic [1:0] quiet_code;
		logic [3:0] dur_code;
	} otd_cfg_t;

	typedef struct packed {
		logic orient_status_read;
		logic tap_status_read;
		logic combined_status_read;
	} otd_reads_t;

	typedef enum logic [2:0] {
		TAP_IDLE,
		TAP_SHOCK1,
		TAP_QUIET,
		TAP_DUR,
		TAP_SHOCK2,
		TAP_WAIT_LOW
	} otd_tap_st_t;

	typedef struct packed {
		otd_axes_t            prev;
		logic [5:0]           cand;
		logic [5:0]           pos;
		logic                 orient_ia;
		logic                 single_ia;
		logic                 double_ia;
		otd_tap_st_t          tap_st;
		logic [OTD_CNT_W-1:0] tap_cnt;
		logic [OTD_CNT_W-1:0] irq_cnt;
		logic [2:0]           tap_sel;
		logic                 tap_neg;
		logic [2:0]           evt_axis;
		logic                 evt_neg;
		logic                 pin_one;
		logic                 pin_two;
		logic [6:0]           orient_status;
		logic [6:0]           tap_status;
	} otd_state_t;

	localparam otd_state_t OTD_STATE_RST = '0;

endpackage

// >>> otd_detector.sv
`timescale 1ns/1ns
module otd_detector
	import otd_pkg::*;
#(
	parameter logic [15:0] ONE_G = OTD_ONE_G_DEF
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Samples, one strobe per output data period
	input  wire logic       sample_valid,
	input  wire otd_axes_t  acc,
	input  wire otd_axes_t  second_lowpass_filter,
	// Configuration
	input  wire otd_cfg_t   cfg,
	// Status read strobes
	input  wire otd_reads_t reads,
	// Interrupt pins and status
	output logic            event_pin_one,
	output logic            event_pin_two,
	output logic [6:0]      orientation_status_reg,
	output logic [6:0]      tap_status_reg
);

	generate
		if (ONE_G == 16'h0000 || ONE_G[15])
		begin : g_bad_one_g
			$error("ONE_G must be nonzero and below half the sample range");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] orient_thr(input logic [1:0] code);
		logic [7:0]  k;
		logic [23:0] p;
		case (code)
			2'h0: k = OTD_ANGLE_K0;
			2'h1: k = OTD_ANGLE_K1;
			2'h2: k = OTD_ANGLE_K2;
			default: k = OTD_ANGLE_K3;
		endcase
		p = 24'(ONE_G) * 24'(k);
		return p[23:8];
	endfunction

	function automatic logic [15:0] mag(input otd_smp_t v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	function automatic otd_smp_t slope(input otd_smp_t cur,
	                                   input otd_smp_t old);
		logic signed [16:0] diff;
		diff = 17'(cur) - 17'(old);
		return diff[16:1];
	endfunction

	function automatic logic [9:0] window(input logic [3:0] code,
	                                      input logic [9:0] def,
	                                      input logic [9:0] lsb);
		return (code == 4'h0) ? def : 10'({6'h00, code} * lsb);
	endfunction

	function automatic logic [15:0] tap_thr(input logic [4:0] t);
		return 16'({11'h000, t} << OTD_TAP_THS_SHIFT);
	endfunction

	////////////////////////////////////////////////////////////////////////
	otd_state_t s_q;
	otd_state_t s_d;
	otd_axes_t  src;
	logic [15:0] othr;
	logic [5:0]  pat;
	logic [2:0]  over;
	logic [5:0]  cand;
	logic        orient_evt;
	otd_smp_t    sl_x;
	otd_smp_t    sl_y;
	otd_smp_t    sl_z;
	logic [2:0]  tover;
	logic [2:0]  pick;
	logic        pick_neg;
	logic        sel_over;
	logic [9:0]  shock_win;
	logic [9:0]  quiet_win;
	logic [9:0]  dur_win;
	logic        orient_latched;
	logic        single_latched;
	logic        double_latched;
	logic        rd_orient;
	logic        rd_tap;
	logic        single_evt;
	logic        double_evt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// orientation data source
	assign src  = cfg.orient_lowpass_select ? second_lowpass_filter : acc;
	assign othr = orient_thr(cfg.orient_angle_threshold);

	assign pat[OTD_POS_XH] = !src.x[15] && mag(src.x) > othr;
	assign pat[OTD_POS_XL] =  src.x[15] && mag(src.x) > othr;
	assign pat[OTD_POS_YH] = !src.y[15] && mag(src.y) > othr;
	assign pat[OTD_POS_YL] =  src.y[15] && mag(src.y) > othr;
	assign pat[OTD_POS_ZH] = !cfg.four_way_orient_enable
		&& !src.z[15] && mag(src.z) > othr;
	assign pat[OTD_POS_ZL] = !cfg.four_way_orient_enable
		&& src.z[15] && mag(src.z) > othr;

	assign over[0] = pat[OTD_POS_XH] | pat[OTD_POS_XL];
	assign over[1] = pat[OTD_POS_YH] | pat[OTD_POS_YL];
	assign over[2] = pat[OTD_POS_ZH] | pat[OTD_POS_ZL];
	assign cand = $onehot(over) ? pat : 6'h00;

	// only a change of position fires
	assign orient_evt = sample_valid && cfg.global_event_enable
		&& cand != 6'h00 && cand == s_q.cand && cand != s_q.pos;

	assign sl_x = slope(acc.x, s_q.prev.x);
	assign sl_y = slope(acc.y, s_q.prev.y);
	assign sl_z = slope(acc.z, s_q.prev.z);

	assign tover[0] = cfg.tap_axis_enable[0]
		&& mag(sl_x) > tap_thr(cfg.tap_threshold_x);
	assign tover[1] = cfg.tap_axis_enable[1]
		&& mag(sl_y) > tap_thr(cfg.tap_threshold_y);
	assign tover[2] = cfg.tap_axis_enable[2]
		&& mag(sl_z) > tap_thr(cfg.tap_threshold_z);

	// Fixed X, Y, Z priority; the programmable order is not modelled
	assign pick = tover[0] ? 3'h1 : tover[1] ? 3'h2 : tover[2] ? 3'h4 : 3'h0;
	assign pick_neg = tover[0] ? sl_x[15] : tover[1] ? sl_y[15] : sl_z[15];
	assign sel_over = |(tover & s_q.tap_sel);

	assign shock_win = window({2'h0, cfg.shock_code},
		OTD_SHOCK_DEF, OTD_SHOCK_LSB);
	assign quiet_win = window({2'h0, cfg.quiet_code},
		OTD_QUIET_DEF, OTD_QUIET_LSB);
	assign dur_win = window(cfg.dur_code, OTD_DUR_DEF, OTD_DUR_LSB);

	assign orient_latched = cfg.latch_request_mode
		&& (cfg.orient_route_pin_one || cfg.orient_route_pin_two);
	assign single_latched = cfg.latch_request_mode
		&& !cfg.single_double_tap_select
		&& (cfg.single_tap_route_one || cfg.single_tap_route_two);
	assign double_latched = cfg.latch_request_mode
		&& cfg.single_double_tap_select
		&& (cfg.double_tap_route_one || cfg.double_tap_route_two);

	assign rd_orient = reads.orient_status_read | reads.combined_status_read;
	assign rd_tap    = reads.tap_status_read | reads.combined_status_read;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d = s_q;
		single_evt = 1'b0;
		double_evt = 1'b0;

		if (orient_latched ? rd_orient : sample_valid)
			s_d.orient_ia = 1'b0;
		if (sample_valid)
		begin
			s_d.cand = cand;
			s_d.prev = acc;
			if (cand != 6'h00 && cand == s_q.cand)
				s_d.pos = cand;
		end
		if (orient_evt)
			s_d.orient_ia = 1'b1;

		if (sample_valid)
		begin
			case (s_q.tap_st)
				TAP_IDLE:
					if (tover != 3'h0)
					begin
						s_d.tap_st  = TAP_SHOCK1;
						s_d.tap_sel = pick;
						s_d.tap_neg = pick_neg;
						s_d.tap_cnt = 10'h001;
					end
				TAP_SHOCK1:
					if (!sel_over)
					begin
						single_evt = 1'b1;
						s_d.tap_cnt = 10'h000;
						s_d.tap_st = cfg.single_double_tap_select
							? TAP_QUIET : TAP_IDLE;
					end
					else if (s_q.tap_cnt >= shock_win)
						s_d.tap_st = TAP_WAIT_LOW;
					else
						s_d.tap_cnt = s_q.tap_cnt + 10'h001;
				TAP_QUIET:
					if (s_q.tap_cnt + 10'h001 >= quiet_win)
					begin
						s_d.tap_st  = TAP_DUR;
						s_d.tap_cnt = 10'h000;
					end
					else
						s_d.tap_cnt = s_q.tap_cnt + 10'h001;
				TAP_DUR:
					if (tover != 3'h0)
					begin
						s_d.tap_st  = TAP_SHOCK2;
						s_d.tap_sel = pick;
						s_d.tap_neg = pick_neg;
						s_d.tap_cnt = 10'h001;
					end
					else if (s_q.tap_cnt + 10'h001 >= dur_win)
						s_d.tap_st = TAP_IDLE;
					else
						s_d.tap_cnt = s_q.tap_cnt + 10'h001;
				TAP_SHOCK2:
					if (!sel_over)
					begin
						double_evt = 1'b1;
						s_d.tap_st = TAP_IDLE;
					end
					else if (s_q.tap_cnt >= shock_win)
						s_d.tap_st = TAP_WAIT_LOW;
					else
						s_d.tap_cnt = s_q.tap_cnt + 10'h001;
				TAP_WAIT_LOW:
					if (tover == 3'h0)
						s_d.tap_st = TAP_IDLE;
				default:
					s_d.tap_st = TAP_IDLE;
			endcase
		end
		if (!cfg.global_event_enable)
			s_d.tap_st = TAP_IDLE;

		if (sample_valid && s_q.irq_cnt != 10'h000)
			s_d.irq_cnt = s_q.irq_cnt - 10'h001;
		if (s_d.irq_cnt == 10'h000 && !single_latched)
			s_d.single_ia = 1'b0;
		if (s_d.irq_cnt == 10'h000 && !double_latched)
			s_d.double_ia = 1'b0;
		if (rd_tap && single_latched)
			s_d.single_ia = 1'b0;
		if (rd_tap && double_latched)
			s_d.double_ia = 1'b0;

		// Events set after clears so a clash keeps the event
		if (single_evt || double_evt)
		begin
			s_d.irq_cnt  = quiet_win;
			s_d.evt_axis = s_q.tap_sel;
			s_d.evt_neg  = s_q.tap_neg;
		end
		if (single_evt)
			s_d.single_ia = 1'b1;
		if (double_evt)
			s_d.double_ia = 1'b1;

		s_d.pin_one = (s_d.orient_ia && cfg.orient_route_pin_one)
			|| (s_d.single_ia && cfg.single_tap_route_one)
			|| (s_d.double_ia && cfg.double_tap_route_one);
		s_d.pin_two = (s_d.orient_ia && cfg.orient_route_pin_two)
			|| (s_d.single_ia && cfg.single_tap_route_two)
			|| (s_d.double_ia && cfg.double_tap_route_two);
		s_d.orient_status = {s_d.orient_ia, s_d.pos};
		s_d.tap_status = {s_d.single_ia | s_d.double_ia, s_d.single_ia,
			s_d.double_ia, s_d.evt_neg,
			s_d.evt_axis[0], s_d.evt_axis[1], s_d.evt_axis[2]};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= OTD_STATE_RST;
		else
			s_q <= s_d;
	end

	assign event_pin_one          = s_q.pin_one;
	assign event_pin_two          = s_q.pin_two;
	assign orientation_status_reg = s_q.orient_status;
	assign tap_status_reg         = s_q.tap_status;

	////////////////////////////////////////////////////////////////////////
	sequence s_stuck_high;
		sample_valid && s_q.tap_st == TAP_SHOCK1 && sel_over
			&& s_q.tap_cnt >= shock_win && cfg.global_event_enable;
	endsequence

	sequence s_short_shock;
		s_q.tap_st == TAP_SHOCK1 && !sel_over && s_q.tap_cnt <= shock_win;
	endsequence

	a_orient_needs_enable:
	assert property ($rose(s_q.orient_ia) |-> $past(cfg.global_event_enable))
	else $error("orientation event without global enable");

	a_orient_pulse_len:
	assert property (s_q.orient_ia && sample_valid && !orient_latched
		&& !orient_evt |=> !s_q.orient_ia)
	else $error("unlatched orientation flag outlived one sample");

	a_orient_latch_hold:
	assert property (s_q.orient_ia && orient_latched && !rd_orient
		|=> s_q.orient_ia)
	else $error("latched orientation flag dropped without read");

	a_orient_onehot_pos:
	assert property (s_q.orient_ia |-> $onehot(s_q.pos))
	else $error("orientation flag without exactly one position bit");

	a_four_way_noz:
	assert property (orient_evt && cfg.four_way_orient_enable
		|=> s_q.pos[OTD_POS_ZH:OTD_POS_ZL] == 2'h0)
	else $error("Z position reported in four-way mode");

	a_orient_change_only:
	assert property (orient_evt |=> s_q.pos != $past(s_q.pos))
	else $error("orientation event without a change of position");

	a_single_tap_cause:
	assert property (single_evt && sample_valid |-> s_short_shock)
	else $error("single tap outside shock window");

	a_shock_timeout:
	assert property (s_stuck_high |=> s_q.tap_st == TAP_WAIT_LOW
		&& !$rose(s_q.single_ia))
	else $error("over-long shock did not abandon the tap");

	a_single_pulse_len:
	assert property ($rose(s_q.single_ia) && !single_latched
		|-> s_q.irq_cnt == quiet_win)
	else $error("single tap pulse not loaded with quiet window");

	a_double_needs_mode:
	assert property ($rose(s_q.double_ia)
		|-> $past(cfg.single_double_tap_select)
		&& $past(s_q.tap_st) == TAP_SHOCK2)
	else $error("double tap outside double mode second shock");

	a_double_latch_hold:
	assert property (s_q.double_ia && double_latched && !rd_tap
		##1 double_latched |-> s_q.double_ia)
	else $error("latched double tap dropped without read");

endmodule

// >>> otd_host_model.sv
`timescale 1ns/1ns
module otd_host_model
	import otd_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Event pins and acknowledge control
	input  wire logic       pin_one,
	input  wire logic       pin_two,
	input  wire logic       ack_en,
	input  wire logic [3:0] ack_dly,
	input  wire otd_reads_t kind,
	// Status reads
	output otd_reads_t      reads
);
	int n;

	// Pins sampled mid-cycle, away from the edge that updates them
	initial
	begin
		reads = '0;
		forever
		begin
			@(negedge clk);
			if (rst_n && ack_en && (pin_one || pin_two))
			begin
				repeat (ack_dly) @(posedge clk);
				reads <= kind;
				@(posedge clk);
				reads <= '0;
				n = 0;
				while ((pin_one || pin_two) && n < 16)
				begin
					@(negedge clk);
					n++;
				end
			end
		end
	end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top
	import otd_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic        sample_valid;
	otd_axes_t   acc;
	otd_axes_t   lpf;
	otd_cfg_t    cfg;
	otd_reads_t  reads;
	otd_reads_t  kind;
	logic        ack_en;
	logic        event_pin_one;
	logic        event_pin_two;
	logic [6:0]  orientation_status_reg;
	logic [6:0]  tap_status_reg;
	logic [31:0] seed;
	int          errors;
	int          samples_checked;
	logic [31:0] q[$];
	otd_smp_t    cx;
	otd_axes_t   v;
	logic [15:0] thr;
	logic [7:0]  kt [4];

	otd_detector u_otd_detector (
		.clk(clk), .rst_n(rst_n), .sample_valid(sample_valid), .acc(acc),
		.second_lowpass_filter(lpf), .cfg(cfg), .reads(reads),
		.event_pin_one(event_pin_one), .event_pin_two(event_pin_two),
		.orientation_status_reg(orientation_status_reg),
		.tap_status_reg(tap_status_reg)
	);

	otd_host_model u_otd_host_model (
		.clk(clk), .rst_n(rst_n), .pin_one(event_pin_one),
		.pin_two(event_pin_two), .ack_en(ack_en), .ack_dly(4'h2),
		.kind(kind), .reads(reads)
	);

	////////////////////////////////////////
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Expectation as {mask, value}
	task automatic note(input logic [15:0] e, input logic [15:0] m);
		q.push_back({m, e});
	endtask

	task automatic smp(input otd_axes_t a, input otd_axes_t f);
		@(posedge clk);
		sample_valid <= 1'b1;
		acc <= a;
		lpf <= f;
		@(posedge clk);
		sample_valid <= 1'b0;
		#1;
	endtask

	task automatic hold(input int n);
		repeat (n) smp(v, v);
	endtask

	// Small noise on the other axes keeps them below every threshold
	function automatic otd_axes_t pv(input int i, input logic [15:0] m);
		otd_axes_t a;
		otd_smp_t  s;
		a.x = otd_smp_t'($random(seed) & 32'h3ff);
		a.y = otd_smp_t'($random(seed) & 32'h3ff);
		a.z = otd_smp_t'($random(seed) & 32'h3ff);
		s = (i % 2) ? otd_smp_t'(m) : -otd_smp_t'(m);
		case (i / 2)
			0: a.x = s;
			1: a.y = s;
			default: a.z = s;
		endcase
		return a;
	endfunction

	task automatic pos2(input int i, input logic [15:0] m);
		v = pv(i, m);
		hold(2);
	endtask

	task automatic tap(input otd_smp_t d);
		cx = cx + d;
		v = '0;
		v.x = cx;
		hold(2);
	endtask

	// Steady slope for n samples, then one flat sample
	task automatic ramp(input int n, input otd_smp_t d);
		repeat (n)
		begin
			cx = cx + d;
			v = '0;
			v.x = cx;
			hold(1);
		end
		hold(1);
	endtask

	////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		logic [31:0] n;
		forever
		begin
			wait (q.size() > 0);
			n = q.pop_front();
			chk({event_pin_one, event_pin_two, orientation_status_reg,
				tap_status_reg} & n[31:16], n[15:0] & n[31:16]);
		end
	end

	initial
	begin
		#40000;
		errors++;
		tally_and_finish();
	end

	initial
	begin
		seed = 32'hab4f0977;
		sample_valid = 1'b0;
		acc = '0;
		lpf = '0;
		cfg = '0;
		kind = '0;
		ack_en = 1'b0;
		rst_n = 1'b0;
		errors = 0;
		samples_checked = 0;
		cx = '0;
		v = '0;
		kt = '{OTD_ANGLE_K0, OTD_ANGLE_K1, OTD_ANGLE_K2, OTD_ANGLE_K3};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cfg.global_event_enable <= 1'b1;
		cfg.orient_route_pin_one <= 1'b1;
		cfg.orient_angle_threshold <= 2'h2;
		for (int i = 0; i < 6; i++)
		begin
			pos2(i, 16'h4000 | 16'($random(seed)) & 16'h3fff);
			note({3'b101, 6'(1 << i), 7'h00}, 16'hff80);
			hold(1);
			note({3'b000, 6'(1 << i), 7'h00}, 16'hff80);
		end
		v.x = 16'h5000;
		hold(2);
		note(16'h0000, 16'he000);
		for (int c = 0; c < 4; c++)
		begin
			@(posedge clk);
			cfg.orient_angle_threshold <= 2'(c);
			thr = 16'((32'(OTD_ONE_G_DEF) * kt[c]) >> 8);
			pos2(2 + c % 2, thr);
			note(16'h0000, 16'he000);
			pos2(2 + c % 2, thr + 16'h0001);
			note({3'b101, 6'(4 << (c % 2)), 7'h00}, 16'hff80);
		end
		@(posedge clk);
		cfg.four_way_orient_enable <= 1'b1;
		pos2(5, 16'h5000);
		note(16'h0000, 16'he000);
		pos2(1, 16'h5000);
		note({3'b101, 6'h02, 7'h00}, 16'hff80);
		@(posedge clk);
		cfg.four_way_orient_enable <= 1'b0;
		cfg.orient_lowpass_select <= 1'b1;
		cfg.orient_route_pin_two <= 1'b1;
		smp(pv(0, 16'h5000), pv(3, 16'h5000));
		smp(pv(0, 16'h5000), pv(3, 16'h5000));
		note({3'b111, 6'h08, 7'h00}, 16'hff80);
		@(posedge clk);
		cfg.orient_lowpass_select <= 1'b0;
		cfg.orient_route_pin_two <= 1'b0;
		cfg.global_event_enable <= 1'b0;
		pos2(1, 16'h5000);
		note({3'b000, 6'h02, 7'h00}, 16'hff80);
		@(posedge clk);
		cfg.global_event_enable <= 1'b1;
		cfg.latch_request_mode <= 1'b1;
		pos2(2, 16'h5000);
		hold(1);
		note({3'b101, 6'h04, 7'h00}, 16'hff80);
		@(posedge clk);
		kind <= '{1'b1, 1'b0, 1'b0};
		ack_en <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		note({3'b000, 6'h04, 7'h00}, 16'hff80);
		@(posedge clk);
		ack_en <= 1'b0;
		cfg.orient_route_pin_one <= 1'b0;
		pos2(0, 16'h5000);
		note({3'b001, 6'h01, 7'h00}, 16'hff80);
		hold(1);
		note({3'b000, 6'h01, 7'h00}, 16'hff80);
		v = '0;
		hold(2);
		@(posedge clk);
		cfg.latch_request_mode <= 1'b0;
		cfg.tap_axis_enable <= 3'b001;
		cfg.tap_threshold_x <= 5'h02;
		cfg.single_tap_route_one <= 1'b1;
		cfg.double_tap_route_two <= 1'b1;
		tap(-16'sh2000);
		note({1'b1, 8'h00, 7'h6c}, 16'h807f);
		hold(1);
		note(16'h8040, 16'h8040);
		hold(1);
		note(16'h0000, 16'h8040);
		tap(16'sh1000);
		note(16'h0000, 16'h8040);
		ramp(4, -16'sh1400);
		note({1'b1, 8'h00, 7'h6c}, 16'h807f);
		ramp(5, 16'sh1400);
		note(16'h0000, 16'h8040);
		@(posedge clk);
		cfg.shock_code <= 2'h1;
		cfg.quiet_code <= 2'h1;
		ramp(5, 16'sh1400);
		note({1'b1, 8'h00, 7'h64}, 16'h807f);
		hold(3);
		note(16'h8040, 16'h8040);
		hold(1);
		note(16'h0000, 16'h8040);
		@(posedge clk);
		cfg.shock_code <= 2'h0;
		cfg.quiet_code <= 2'h0;
		cfg.single_double_tap_select <= 1'b1;
		hold(20);
		tap(-16'sh2000);
		hold(20);
		tap(-16'sh2000);
		note(16'h0000, 16'h4010);
		hold(20);
		@(posedge clk);
		cfg.latch_request_mode <= 1'b1;
		tap(-16'sh2000);
		hold(3);
		tap(16'sh2000);
		note(16'h4010, 16'h4010);
		hold(3);
		note(16'h4010, 16'h4010);
		@(posedge clk);
		kind <= '{1'b0, 1'b0, 1'b1};
		ack_en <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		note(16'h0000, 16'h4010);
		#1;
		tally_and_finish();
	end
endmodule
